// ==== logic/aias_cfg.svh ====
`ifndef AIAS_CFG_SVH
`define AIAS_CFG_SVH

// Register byte offsets.
`define AIAS_OFF_CTRL       8'h00
`define AIAS_OFF_AVG        8'h04
`define AIAS_OFF_PRANGE     8'h08
`define AIAS_OFF_SLIMIT0    8'h0C
`define AIAS_OFF_OUT        8'h40
`define AIAS_OFF_MSTAT      8'h44
`define AIAS_OFF_MEAN       8'h48

// Control register fields.
`define AIAS_CTRL_MULTI     0
`define AIAS_CTRL_REDUCED   1
`define AIAS_CTRL_HIDE      2
`define AIAS_CTRL_CODE_LSB  3
`define AIAS_CTRL_RST       32'h0000_0000

// Averaging register fields: cycles [4:0], scans [13:8].
`define AIAS_AVG_CYC_LSB    0
`define AIAS_AVG_SCN_LSB    8
`define AIAS_AVG_RST        32'h0000_2001

// Timing.
`define AIAS_CLK_HZ         40000000
`define AIAS_CYCLE_US       4000
`define AIAS_CYCLE_CLKS     ((`AIAS_CLK_HZ / 1000000) * `AIAS_CYCLE_US)
`define AIAS_DIAG_MS        200
`define AIAS_DIAG_CLKS      ((`AIAS_CLK_HZ / 1000) * `AIAS_DIAG_MS)

`endif

// ==== logic/aias_pkg.sv ====
package aias_pkg;

	typedef enum logic [1:0] {
		CODE_ONE_OF_N = 2'b00,
		CODE_BINARY   = 2'b01,
		CODE_LEVEL    = 2'b10,
		CODE_INV_LVL  = 2'b11
	} aias_code_e;

	// Flags presented to the logic program.
	typedef struct packed {
		logic [6:0] range_bits;
		logic       sensor_ok;
		logic       enable;
	} aias_flags_s;

	// One sensor sample with its validity checks.
	typedef struct packed {
		logic [15:0] value;
		logic        valid;
		logic        discrepancy;
	} aias_sample_s;

endpackage

// ==== logic/aias_top.sv ====
// The AHB-Lite register port and the placing of the registers were decided locally.
`include "aias_cfg.svh"

module aias_top #(
	parameter int CYCLE_CLKS = `AIAS_CYCLE_CLKS,
	parameter int DIAG_CLKS  = `AIAS_DIAG_CLKS,
	parameter int MAX_SCANS  = 32,
	parameter int MAX_CYC    = 25,
	parameter int N_RANGES   = 15
) (
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	input  wire aias_pkg::aias_sample_s sample,
	input  wire logic                 sample_stb,
	input  wire logic [3:0]           prange_sel,
	output aias_pkg::aias_flags_s     flags,
	output logic [31:0]               module_status
);

	// The cycle and refresh counters are 22 and 24 bits wide.
	if (MAX_SCANS != 32 || MAX_CYC < 1 || MAX_CYC > 31 ||
	    N_RANGES != 15 || CYCLE_CLKS < 64 || CYCLE_CLKS > 4194304 ||
	    DIAG_CLKS < 2 || DIAG_CLKS > 16777216) begin : g_bad_param
		$error("aias_top: unsupported parameter values");
	end

	// ------------------------------------------------------------
	// AHB-Lite register slave
	// ------------------------------------------------------------
	logic [31:0] ctrl_ff, avg_ff, prange_en_ff;
	logic [15:0] slimit_ff [1:N_RANGES-1];
	logic        wr_pend_ff;
	logic [7:0]  wr_addr_ff;
	logic [31:0] rd_mux;
	logic [15:0] mean_ff;
	logic        mean_valid_ff;
	logic        discr_ff;
	logic [31:0] mstat_ff;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
		end else begin
			wr_pend_ff <= hsel && hready && htrans[1] && hwrite;
			wr_addr_ff <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ff      <= `AIAS_CTRL_RST;
			avg_ff       <= `AIAS_AVG_RST;
			prange_en_ff <= 32'h0000_0000;
		end else if (wr_pend_ff) begin
			case (wr_addr_ff)
			`AIAS_OFF_CTRL:   ctrl_ff      <= {27'h0, hwdata[4:0]};
			`AIAS_OFF_AVG:    avg_ff       <= {18'h0, hwdata[13:8],
			                                   3'h0, hwdata[4:0]};
			`AIAS_OFF_PRANGE: prange_en_ff <= {28'h0, hwdata[3:0]};
			default:          ;
			endcase
		end
	end

	genvar gi;
	generate
		for (gi = 1; gi < N_RANGES; gi++) begin : g_lim
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn)
					slimit_ff[gi] <= 16'(gi * 4096);
				else if (wr_pend_ff && wr_addr_ff ==
				         8'(`AIAS_OFF_SLIMIT0 + 4 * (gi - 1)))
					slimit_ff[gi] <= hwdata[15:0];
			end
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (hsel && hready && htrans[1] && !hwrite)
			hrdata <= rd_mux;
	end

	// ------------------------------------------------------------
	// Averaging
	// ------------------------------------------------------------
	logic        reduced, multi, hide;
	logic [4:0]  cfg_cyc;
	logic [5:0]  cfg_scans, eff_scans;
	logic [4:0]  eff_cyc;
	logic [21:0] cyc_cnt_ff;
	logic        tick;
	logic [5:0]  scan_cnt_ff;
	logic [21:0] scan_sum_ff;
	logic        scan_bad_ff, scan_disc_ff;
	logic [15:0] cyc_mean;
	logic [15:0] hist_ff [0:MAX_CYC-1];
	logic [4:0]  hist_fill_ff;
	logic [20:0] slide_sum_ff, nxt_slide_sum;

	assign reduced   = ctrl_ff[`AIAS_CTRL_REDUCED];
	assign multi     = ctrl_ff[`AIAS_CTRL_MULTI] && !reduced;
	assign hide      = ctrl_ff[`AIAS_CTRL_HIDE];
	assign cfg_cyc   = avg_ff[`AIAS_AVG_CYC_LSB +: 5];
	assign cfg_scans = avg_ff[`AIAS_AVG_SCN_LSB +: 6];
	// Reduced scan count, clamped to 1..32; else always 32.
	assign eff_scans = !reduced ? 6'(MAX_SCANS) :
	                   (cfg_scans == 6'h00) ? 6'h01 :
	                   (cfg_scans > 6'(MAX_SCANS)) ? 6'(MAX_SCANS) :
	                   cfg_scans;
	assign eff_cyc   = !multi ? 5'h01 :
	                   (cfg_cyc == 5'h00) ? 5'h01 :
	                   (cfg_cyc > 5'(MAX_CYC)) ? 5'(MAX_CYC) :
	                   cfg_cyc;
	assign tick      = (cyc_cnt_ff == 22'(CYCLE_CLKS - 1));
	assign cyc_mean  = 16'(scan_sum_ff / 22'(scan_cnt_ff == 6'h00 ?
	                   6'h01 : scan_cnt_ff));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cyc_cnt_ff <= 22'h00_0000;
		else
			cyc_cnt_ff <= tick ? 22'h00_0000 : cyc_cnt_ff + 22'h00_0001;
	end

	// Scans beyond the configured count in one cycle are dropped.
	// A scan on the boundary opens the next cycle instead of being lost.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scan_cnt_ff  <= 6'h00;
			scan_sum_ff  <= 22'h00_0000;
			scan_bad_ff  <= 1'b0;
			scan_disc_ff <= 1'b0;
		end else if (tick) begin
			scan_cnt_ff  <= sample_stb ? 6'h01 : 6'h00;
			scan_sum_ff  <= sample_stb ? 22'(sample.value) : 22'h00_0000;
			scan_bad_ff  <= sample_stb && !sample.valid;
			scan_disc_ff <= sample_stb && sample.discrepancy;
		end else if (sample_stb && scan_cnt_ff < eff_scans) begin
			scan_cnt_ff  <= scan_cnt_ff + 6'h01;
			scan_sum_ff  <= scan_sum_ff + 22'(sample.value);
			scan_bad_ff  <= scan_bad_ff | !sample.valid;
			scan_disc_ff <= scan_disc_ff | sample.discrepancy;
		end
	end

	// Sliding window: new cycle mean enters, oldest in window leaves.
	always_comb begin
		nxt_slide_sum = slide_sum_ff + 21'(cyc_mean);
		if (hist_fill_ff >= eff_cyc)
			nxt_slide_sum = nxt_slide_sum - 21'(hist_ff[eff_cyc - 5'h01]);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < MAX_CYC; i++)
				hist_ff[i] <= 16'h0000;
		end else if (tick) begin
			hist_ff[0] <= cyc_mean;
			for (int i = 1; i < MAX_CYC; i++)
				hist_ff[i] <= hist_ff[i-1];
		end
	end

	// A change of window length restarts the fill, so the sum stays exact.
	logic [4:0] last_cyc_ff;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hist_fill_ff  <= 5'h00;
			slide_sum_ff  <= 21'h00_0000;
			mean_ff       <= 16'h0000;
			mean_valid_ff <= 1'b0;
			discr_ff      <= 1'b0;
			last_cyc_ff   <= 5'h01;
		end else if (tick) begin
			last_cyc_ff <= eff_cyc;
			if (last_cyc_ff != eff_cyc) begin
				hist_fill_ff <= 5'h01;
				slide_sum_ff <= 21'(cyc_mean);
				mean_ff      <= cyc_mean;
			end else begin
				if (hist_fill_ff < eff_cyc)
					hist_fill_ff <= hist_fill_ff + 5'h01;
				slide_sum_ff <= nxt_slide_sum;
				mean_ff <= 16'(nxt_slide_sum / 21'((hist_fill_ff < eff_cyc) ?
				           hist_fill_ff + 5'h01 : eff_cyc));
			end
			mean_valid_ff <= !scan_bad_ff && scan_cnt_ff == eff_scans;
			discr_ff      <= scan_disc_ff;
		end
	end

	// ------------------------------------------------------------
	// Evaluation and coding
	// ------------------------------------------------------------
	function automatic logic [6:0] encode(aias_pkg::aias_code_e c,
	                                      logic [3:0] n);
		logic [6:0] r;
		r = 7'h00;
		case (c)
		aias_pkg::CODE_BINARY:   r = {3'h0, n};
		aias_pkg::CODE_ONE_OF_N: r = (n == 4'h0) ? 7'h00 : 7'(7'h01 << (n - 4'h1));
		aias_pkg::CODE_LEVEL:    r = 7'(~(8'hFF << n));
		aias_pkg::CODE_INV_LVL:  r = (n == 4'h0) ? 7'h00 : 7'(7'h7F << n);
		default:                 r = 7'h00;
		endcase
		return r;
	endfunction

	logic        sensor_ok, in_range;
	logic [3:0]  range_num;
	logic [3:0]  sel_valid;

	assign sensor_ok = mean_valid_ff && !discr_ff;
	// Each selected range must be activated; none selected is a violation.
	assign sel_valid = prange_sel & prange_en_ff[3:0];
	assign in_range  = (prange_sel != 4'h0) &&
	                   (sel_valid == prange_sel);

	always_comb begin
		range_num = 4'h1;
		for (int i = 1; i < N_RANGES; i++)
			if (mean_ff >= slimit_ff[i])
				range_num = 4'(i + 1);
		if (!sensor_ok)
			range_num = 4'h0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			flags <= '0;
		else begin
			flags.enable     <= sensor_ok && in_range;
			flags.sensor_ok  <= sensor_ok;
			flags.range_bits <= encode(aias_pkg::aias_code_e'(
			                    ctrl_ff[`AIAS_CTRL_CODE_LSB +: 2]),
			                    range_num);
		end
	end

	// ------------------------------------------------------------
	// Diagnostic status
	// ------------------------------------------------------------
	logic [23:0] diag_cnt_ff;
	logic        diag_tick;
	assign diag_tick = (diag_cnt_ff == 24'(DIAG_CLKS - 1));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			diag_cnt_ff <= 24'h00_0000;
			mstat_ff    <= 32'h0000_0000;
		end else begin
			diag_cnt_ff <= diag_tick ? 24'h00_0000 : diag_cnt_ff + 24'h00_0001;
			if (diag_tick)
				mstat_ff <= {hide ? 16'hFFFF : mean_ff,
				             13'h0000, sensor_ok, !discr_ff, 1'b1};
		end
	end
	assign module_status = mstat_ff;

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (haddr[7:0])
		`AIAS_OFF_CTRL:   rd_mux = ctrl_ff;
		`AIAS_OFF_AVG:    rd_mux = avg_ff;
		`AIAS_OFF_PRANGE: rd_mux = prange_en_ff;
		`AIAS_OFF_OUT:    rd_mux = {23'h0, flags};
		`AIAS_OFF_MSTAT:  rd_mux = mstat_ff;
		`AIAS_OFF_MEAN:   rd_mux = {15'h0, mean_valid_ff, mean_ff};
		default: begin
			for (int i = 1; i < N_RANGES; i++)
				if (haddr[7:0] == 8'(`AIAS_OFF_SLIMIT0 + 4 * (i - 1)))
					rd_mux = {16'h0000, slimit_ff[i]};
		end
		endcase
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_enable_needs_sensor;
		@(posedge hclk) disable iff (!hresetn)
		flags.enable |-> flags.sensor_ok;
	endproperty
	a_enable_needs_sensor: assert property (p_enable_needs_sensor)
		else $error("enable set while sensor status clear");

	property p_no_range_no_enable;
		@(posedge hclk) disable iff (!hresetn)
		prange_sel == 4'h0 |=> !flags.enable;
	endproperty
	a_no_range_no_enable: assert property (p_no_range_no_enable)
		else $error("enable set with no process range");

	property p_invalid_zero;
		@(posedge hclk) disable iff (!hresetn)
		!sensor_ok |=> flags.range_bits == 7'h00;
	endproperty
	a_invalid_zero: assert property (p_invalid_zero)
		else $error("range bits nonzero for invalid value");

	property p_sensor_status;
		@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> flags.sensor_ok == $past(mean_valid_ff && !discr_ff);
	endproperty
	a_sensor_status: assert property (p_sensor_status)
		else $error("sensor status mismatch");

	property p_hide;
		@(posedge hclk) disable iff (!hresetn)
		diag_tick && hide |=> module_status[31:16] == 16'hFFFF;
	endproperty
	a_hide: assert property (p_hide)
		else $error("hidden status bits not all ones");

	property p_value_shown;
		@(posedge hclk) disable iff (!hresetn)
		diag_tick && !hide |=> module_status[31:16] == $past(mean_ff);
	endproperty
	a_value_shown: assert property (p_value_shown)
		else $error("status bits do not carry value");

	property p_status_stable;
		@(posedge hclk) disable iff (!hresetn)
		!$past(diag_tick) |-> $stable(mstat_ff);
	endproperty
	a_status_stable: assert property (p_status_stable)
		else $error("status changed between refreshes");

	property p_scans_bound;
		@(posedge hclk) disable iff (!hresetn)
		!tick && scan_cnt_ff >= eff_scans |=>
		scan_cnt_ff == $past(scan_cnt_ff);
	endproperty
	a_scans_bound: assert property (p_scans_bound)
		else $error("scan count above limit");

	property p_cycle_len;
		@(posedge hclk) disable iff (!hresetn)
		tick |=> !tick [*8];
	endproperty
	a_cycle_len: assert property (p_cycle_len)
		else $error("processing cycle too short");

	c_enable: cover property (@(posedge hclk) disable iff (!hresetn)
		flags.enable);
	c_range_viol: cover property (@(posedge hclk) disable iff (!hresetn)
		flags.sensor_ok && !flags.enable);
	c_multi: cover property (@(posedge hclk) disable iff (!hresetn)
		tick && multi && hist_fill_ff == eff_cyc);

endmodule // aias_top

// ==== testbench/aias_prog_model.sv ====
module aias_prog_model (
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire logic [2:0]             scan_rate,
	input  wire logic [15:0]            scan_value,
	input  wire logic                   scan_valid,
	input  wire logic                   scan_disc,
	input  wire logic [3:0]             prange_req,
	input  wire logic                   restart_req,
	input  wire aias_pkg::aias_flags_s  flags,
	output aias_pkg::aias_sample_s      sample,
	output logic                        sample_stb,
	output logic [3:0]                  prange_sel,
	output logic                        run_ff
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [4:0] phase_ff;
	logic       stb;

	// For scan_rate up to 4, strobes sit at 0, 6, 12 and 18 of every 25 clocks,
	// so any window of 200 clocks holds exactly eight times scan_rate scans,
	// whatever phase the processing cycle has.
	assign stb = (phase_ff < 5'(6 * scan_rate)) && (phase_ff % 5'h6 == 5'h0);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_ff <= 5'h00;
		end else begin
			phase_ff <= (phase_ff == 5'h18) ? 5'h00 : phase_ff + 5'h01;
		end
	end

	// Between scans the lines show inverted data so stale values never match.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sample     <= '0;
			sample_stb <= 1'h0;
		end else begin
			sample_stb         <= stb;
			sample.value       <= stb ? scan_value : ~scan_value;
			sample.valid       <= stb ? scan_valid : ~scan_valid;
			sample.discrepancy <= stb ? scan_disc : ~scan_disc;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prange_sel <= 4'h0;
		end else begin
			prange_sel <= prange_req;
		end
	end

	// The machine restarts only on an explicit request while flags.enable is
	// set, and it stops whenever flags.sensor_ok is clear.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_ff <= 1'h0;
		end else if (!flags.sensor_ok) begin
			run_ff <= 1'h0;
		end else if (restart_req && flags.enable) begin
			run_ff <= 1'h1;
		end
	end
endmodule // aias_prog_model

// ==== testbench/aias_tb_top.sv ====
module aias_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic                   hclk        = 1'h0;
	logic                   hresetn     = 1'h0;
	logic                   hsel        = 1'h0;
	logic [31:0]            haddr       = 32'h0000_0000;
	logic [1:0]             htrans      = 2'h0;
	logic                   hwrite      = 1'h0;
	logic [2:0]             hsize       = 3'h2;
	logic [31:0]            hwdata      = 32'h0000_0000;
	logic [31:0]            hrdata;
	logic                   hreadyout;
	logic                   hresp;
	logic [2:0]             scan_rate   = 3'h1;
	logic [15:0]            scan_value  = 16'h0000;
	logic                   scan_valid  = 1'h1;
	logic                   scan_disc   = 1'h0;
	logic [3:0]             prange_req  = 4'h1;
	logic                   restart_req = 1'h0;
	aias_pkg::aias_sample_s sample;
	logic                   sample_stb;
	logic [3:0]             prange_sel;
	aias_pkg::aias_flags_s  flags;
	logic [31:0]            module_status;
	logic                   run_ff;
	logic [31:0]            rd;
	logic [15:0]            vals [4]    = '{16'h0FFF, 16'h1000,
	                                        16'h2FFF, 16'h5000};
	logic [3:0]             prs [4]     = '{4'h0, 4'h4, 4'h6, 4'h3};
	int                     err_count   = 0;
	int                     check_count = 0;

	aias_top #(.CYCLE_CLKS(200), .DIAG_CLKS(1000)) aias_top_i (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .sample(sample), .sample_stb(sample_stb),
		.prange_sel(prange_sel), .flags(flags), .module_status(module_status)
	);

	aias_prog_model aias_prog_model_i (
		.hclk(hclk), .hresetn(hresetn), .scan_rate(scan_rate),
		.scan_value(scan_value), .scan_valid(scan_valid),
		.scan_disc(scan_disc), .prange_req(prange_req),
		.restart_req(restart_req), .flags(flags), .sample(sample),
		.sample_stb(sample_stb), .prange_sel(prange_sel), .run_ff(run_ff)
	);

	always #12.5 hclk = ~hclk;

	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rdat);
		hsel   <= 1'h1;
		htrans <= 2'h2;
		haddr  <= {24'h000000, a};
		hwrite <= wr;
		hsize  <= 3'h2;
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		hsel   <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		rdat = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'h1, a, d, x);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'h0, a, 32'h0000_0000, x);
		check(x, e);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge hclk);
	endtask

	function automatic logic [6:0] enc(input int n, input int code);
		case (code)
			0: return 7'(1 << (n - 1));
			1: return 7'(n);
			2: return 7'((1 << n) - 1);
			default: return 7'(~((1 << n) - 1));
		endcase
	endfunction

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		rchk(8'h00, 32'h0000_0000);
		rchk(8'h04, 32'h0000_2001);
		rchk(8'h08, 32'h0000_0000);
		rchk(8'h0C, 32'h0000_1000);
		rchk(8'h80, 32'h0000_0000);
		$display("test reset values done");
		wr(8'h04, 32'h0000_0801);
		wr(8'h08, 32'h0000_0003);
		wr(8'h00, 32'h0000_000A);
		for (int i = 0; i < 4; i++) begin
			scan_value <= vals[i];
			settle(600);
			check(32'(flags), 32'({enc(vals[i][15:12] + 1, 1), 2'h3}));
			check(32'(flags.range_bits[6:4]), 32'h0);
			rchk(8'h48, {15'h0000, 1'h1, vals[i]});
		end
		$display("test reduced scans and ranges done");
		scan_value <= 16'h2000;
		for (int c = 0; c < 4; c++) begin
			wr(8'h00, 32'(32'h0000_0002 | (c << 3)));
			settle(400);
			check(32'(flags.range_bits), 32'(enc(3, c)));
		end
		$display("test codings done");
		wr(8'h00, 32'h0000_000A);
		for (int i = 0; i < 4; i++) begin
			prange_req <= prs[i];
			settle(400);
			check(32'(flags), 32'({enc(3, 1), 1'h1, 1'(i == 3)}));
		end
		settle(1200);
		check(32'({module_status[31:16], module_status[2:0]}),
			32'h0001_0007);
		wr(8'h00, 32'h0000_000E);
		settle(1200);
		check(32'(module_status[31:16]), 32'h0000_FFFF);
		$display("test process range and status done");
		wr(8'h00, 32'h0000_000A);
		scan_disc <= 1'h1;
		settle(600);
		check(32'(flags), 32'h0000_0000);
		settle(1200);
		check(32'(module_status[2:0]), 32'h0000_0001);
		scan_disc  <= 1'h0;
		scan_valid <= 1'h0;
		settle(600);
		check(32'(flags), 32'h0000_0000);
		scan_valid <= 1'h1;
		settle(600);
		restart_req <= 1'h1;
		settle(1);
		restart_req <= 1'h0;
		check(32'(flags), 32'({enc(3, 1), 2'h3}));
		$display("test sensor errors done");
		wr(8'h04, 32'h0000_0804);
		wr(8'h00, 32'h0000_0009);
		scan_rate  <= 3'h4;
		scan_value <= 16'h1000;
		settle(1400);
		rchk(8'h48, 32'h0001_1000);
		scan_value <= 16'h5000;
		settle(400);
		bus(1'h0, 8'h48, 32'h0000_0000, rd);
		check(32'(rd[16] && rd[15:0] > 16'h1000 && rd[15:0] < 16'h5000),
			32'h0000_0001);
		settle(1000);
		rchk(8'h48, 32'h0001_5000);
		$display("test multi-cycle averaging done");
		wr(8'h00, 32'h0000_000B);
		scan_rate  <= 3'h1;
		scan_value <= 16'h1000;
		settle(600);
		scan_value <= 16'h5000;
		settle(400);
		rchk(8'h48, 32'h0001_5000);
		$display("test reduced overrides multi done");
		summarize();
	end

	initial begin
		repeat (60000) @(posedge hclk);
		err_count++;
		summarize();
	end
endmodule // aias_tb_top
